/* File: core/ccr_flags_pkg.sv */
package ccr_flags_pkg;
   // Flag positions inside the condition code register.
   localparam int unsigned CARRY_BIT = 0;
   localparam int unsigned OVERFLOW_BIT = 1;
   localparam int unsigned ZERO_BIT = 2;
   localparam int unsigned NEGATIVE_BIT = 3;
   localparam int unsigned HALF_CARRY_BIT = 5;
   localparam logic [7:0] CCR_RESET = 8'h00;

   // Avalon byte addresses.
   localparam logic [3:0] FLAGS_ADDR = 4'h0;
   localparam logic [3:0] OPCOUNT_ADDR = 4'h4;
   localparam logic [15:0] OPCOUNT_RESET = 16'h0000;

   typedef enum logic [1:0] {
      size_byte,
      size_word,
      size_long
   } size_e;

   typedef enum logic [4:0] {
      add_op,
      add_with_carry_op,
      subtract_op,
      subtract_with_carry_op,
      negate_op,
      decimal_adjust_add_op,
      decimal_adjust_sub_op,
      increment_op,
      decrement_op,
      signed_divide_op,
      unsigned_divide_op,
      signed_multiply_op,
      unsigned_multiply_op,
      logic_move_op,
      zero_extend_op,
      shift_left_op,
      arith_shift_left_op,
      shift_right_op,
      logic_shift_right_op,
      test_and_set_op,
      control_register_load_op,
      bit_inverted_xor_op,
      bit_xor_op,
      bit_load_op,
      bit_inverted_load_op,
      bit_and_op,
      bit_inverted_and_op,
      bit_or_op,
      bit_inverted_or_op,
      bit_test_op,
      no_flag_op
   } op_e;

   typedef struct packed {
      op_e code;
      size_e size;
      logic two_bit;
      logic to_extended;
      logic [31:0] src;
      logic [31:0] dst;
      logic [31:0] res;
      logic [31:0] res_hi;
      logic dec_carry;
      logic bit_val;
   } op_s;
endpackage

/* File: core/condition_code_flag_logic.sv */
// Function
// - Flag loads, flag immediates, exception return copy result bits.
// - Those operations on the extended control register change no flag.
// - Zero when all result bits clear; negative copies result top bit.
// - Addition half-carry is carry out of bit m-4.
// - Addition overflow when operand signs agree and result sign differs.
// - Addition carry is carry out of the top bit.
// - Subtract and compare half-carry is borrow out of bit m-4.
// - Subtract and compare carry is borrow out of the top bit.
// - Carry-chained add and subtract keep zero only if already set.
// - Decimal adjust add takes decimal carry; H and V undefined.
// - Decimal adjust subtract takes decimal borrow; H and V undefined.
// - Increment overflow when destination top zero and result top one.
// - Decrement overflow when destination top one and result top zero.
// - Signed divide negative is XOR of divisor and dividend signs.
// - Divides set zero on zero divisor; unsigned N is divisor top.
// - Signed multiply flags from double product; unsigned changes none.
// - Left shifts take carry from top bit, or bit below for two bits.
// - Right shifts take carry from bit 0, or bit 1 for two bits.
// - Test-and-set flags from operand before the set; overflow cleared.
// - Bit inverted XOR carry is XNOR; bit XOR carry is XOR.
module condition_code_flag_logic (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic op_valid_in,
   input wire ccr_flags_pkg::op_s op_in,
   output logic [7:0] ccr_out,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);
   localparam int unsigned HB = ccr_flags_pkg::HALF_CARRY_BIT;
   localparam int unsigned NB = ccr_flags_pkg::NEGATIVE_BIT;
   localparam int unsigned ZB = ccr_flags_pkg::ZERO_BIT;
   localparam int unsigned VB = ccr_flags_pkg::OVERFLOW_BIT;
   localparam int unsigned CB = ccr_flags_pkg::CARRY_BIT;

   logic [7:0] ccr_q;
   logic [7:0] ccr_d;
   logic [15:0] opcount_q;
   logic ack_q;
   logic [31:0] rdata_q;

   function automatic logic [5:0] top_idx(input ccr_flags_pkg::size_e sz);
      case (sz)
         ccr_flags_pkg::size_byte: top_idx = 6'h07;
         ccr_flags_pkg::size_word: top_idx = 6'h0F;
         default: top_idx = 6'h1F;
      endcase
   endfunction

   // True when bits idx down to 0 of v are all zero.
   function automatic logic zero_to(input logic [63:0] v,
                                    input logic [5:0] idx);
      logic [63:0] mask;
      mask = ~(64'hFFFFFFFFFFFFFFFE << idx);
      zero_to = ~|(v & mask);
   endfunction

   wire [5:0] m = top_idx(op_in.size);
   wire [5:0] m2 = {m[4:0], 1'b1};
   wire [5:0] m4 = m - 6'h04;
   wire [5:0] m1 = m - 6'h01;
   wire [5:0] mm2 = m - 6'h02;
   wire [63:0] src_w = {32'h0, op_in.src};
   wire [63:0] dst_w = {op_in.res_hi, op_in.dst};
   wire [63:0] res_w = {op_in.res_hi, op_in.res};
   wire [63:0] dst_lo = {32'h0, op_in.dst};
   wire [63:0] res_lo = {32'h0, op_in.res};
   wire sm = src_w[m];
   wire dm = dst_lo[m];
   wire rm = res_lo[m];
   wire s4 = src_w[m4];
   wire d4 = dst_lo[m4];
   wire r4 = res_lo[m4];
   wire dm1 = dst_lo[m1];
   wire dm2 = dst_lo[mm2];
   wire res_zero = zero_to(res_lo, m);
   wire add_h = (s4 & d4) | (d4 & ~r4) | (s4 & ~r4);
   wire add_v = (sm & dm & ~rm) | (~sm & ~dm & rm);
   wire add_c = (sm & dm) | (dm & ~rm) | (sm & ~rm);
   wire sub_h = (s4 & ~d4) | (~d4 & r4) | (s4 & r4);
   wire sub_v = (~sm & dm & ~rm) | (sm & ~dm & rm);
   wire sub_c = (sm & ~dm) | (~dm & rm) | (sm & rm);
   wire left_c = op_in.two_bit ? dm1 : dm;
   wire right_c = op_in.two_bit ? dst_lo[1] : dst_lo[0];
   wire shal_v = op_in.two_bit ? ~((dm & dm1 & dm2) | (~dm & ~dm1 & ~dm2))
                               : (dm ^ dm1);
   wire c_old = ccr_q[CB];
   wire bv = op_in.bit_val;
   wire flags_hit = avs_address_in == ccr_flags_pkg::FLAGS_ADDR;
   wire count_hit = avs_address_in == ccr_flags_pkg::OPCOUNT_ADDR;
   wire sw_write = avs_write_in & ack_q & flags_hit & avs_byteenable_in[0];

   always_comb begin
      ccr_d = ccr_q;
      case (op_in.code)
         ccr_flags_pkg::add_op,
         ccr_flags_pkg::add_with_carry_op: begin
            ccr_d[HB] = add_h;
            ccr_d[NB] = rm;
            ccr_d[VB] = add_v;
            ccr_d[CB] = add_c;
            if (op_in.code == ccr_flags_pkg::add_op) begin
               ccr_d[ZB] = res_zero;
            end else begin
               ccr_d[ZB] = ccr_q[ZB] & res_zero;
            end
         end
         ccr_flags_pkg::subtract_op,
         ccr_flags_pkg::subtract_with_carry_op: begin
            ccr_d[HB] = sub_h;
            ccr_d[NB] = rm;
            ccr_d[VB] = sub_v;
            ccr_d[CB] = sub_c;
            if (op_in.code == ccr_flags_pkg::subtract_op) begin
               ccr_d[ZB] = res_zero;
            end else begin
               ccr_d[ZB] = ccr_q[ZB] & res_zero;
            end
         end
         ccr_flags_pkg::negate_op: begin
            ccr_d[HB] = d4 | r4;
            ccr_d[NB] = rm;
            ccr_d[ZB] = res_zero;
            ccr_d[VB] = dm & rm;
            ccr_d[CB] = dm | rm;
         end
         // Half-carry and overflow are undefined here and are kept.
         ccr_flags_pkg::decimal_adjust_add_op,
         ccr_flags_pkg::decimal_adjust_sub_op: begin
            ccr_d[NB] = rm;
            ccr_d[ZB] = res_zero;
            ccr_d[CB] = op_in.dec_carry;
         end
         ccr_flags_pkg::increment_op: begin
            ccr_d[NB] = rm;
            ccr_d[ZB] = res_zero;
            ccr_d[VB] = ~dm & rm;
         end
         ccr_flags_pkg::decrement_op: begin
            ccr_d[NB] = rm;
            ccr_d[ZB] = res_zero;
            ccr_d[VB] = dm & ~rm;
         end
         ccr_flags_pkg::signed_divide_op: begin
            ccr_d[NB] = sm ^ dst_w[m2];
            ccr_d[ZB] = zero_to(src_w, m);
         end
         ccr_flags_pkg::unsigned_divide_op: begin
            ccr_d[NB] = sm;
            ccr_d[ZB] = zero_to(src_w, m);
         end
         ccr_flags_pkg::signed_multiply_op: begin
            ccr_d[NB] = res_w[m2];
            ccr_d[ZB] = zero_to(res_w, m2);
         end
         ccr_flags_pkg::logic_move_op: begin
            ccr_d[NB] = rm;
            ccr_d[ZB] = res_zero;
            ccr_d[VB] = 1'b0;
         end
         ccr_flags_pkg::zero_extend_op: begin
            ccr_d[NB] = 1'b0;
            ccr_d[ZB] = res_zero;
            ccr_d[VB] = 1'b0;
         end
         ccr_flags_pkg::shift_left_op,
         ccr_flags_pkg::arith_shift_left_op: begin
            ccr_d[NB] = rm;
            ccr_d[ZB] = res_zero;
            ccr_d[CB] = left_c;
            if (op_in.code == ccr_flags_pkg::arith_shift_left_op) begin
               ccr_d[VB] = shal_v;
            end else begin
               ccr_d[VB] = 1'b0;
            end
         end
         ccr_flags_pkg::shift_right_op,
         ccr_flags_pkg::logic_shift_right_op: begin
            ccr_d[NB] = (op_in.code == ccr_flags_pkg::shift_right_op) & rm;
            ccr_d[ZB] = res_zero;
            ccr_d[VB] = 1'b0;
            ccr_d[CB] = right_c;
         end
         ccr_flags_pkg::test_and_set_op: begin
            ccr_d[NB] = dm;
            ccr_d[ZB] = zero_to(dst_lo, m);
            ccr_d[VB] = 1'b0;
         end
         ccr_flags_pkg::control_register_load_op: begin
            if (!op_in.to_extended) begin
               ccr_d = op_in.res[7:0];
            end
         end
         ccr_flags_pkg::bit_inverted_xor_op: begin
            ccr_d[CB] = ~(c_old ^ bv);
         end
         ccr_flags_pkg::bit_xor_op: ccr_d[CB] = c_old ^ bv;
         ccr_flags_pkg::bit_load_op: ccr_d[CB] = bv;
         ccr_flags_pkg::bit_inverted_load_op: ccr_d[CB] = ~bv;
         ccr_flags_pkg::bit_and_op: ccr_d[CB] = c_old & bv;
         ccr_flags_pkg::bit_inverted_and_op: ccr_d[CB] = c_old & ~bv;
         ccr_flags_pkg::bit_or_op: ccr_d[CB] = c_old | bv;
         ccr_flags_pkg::bit_inverted_or_op: ccr_d[CB] = c_old | ~bv;
         ccr_flags_pkg::bit_test_op: ccr_d[ZB] = ~bv;
         default: ccr_d = ccr_q;
      endcase
   end

   // An instruction update wins over a software write in the same cycle.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ccr_q <= ccr_flags_pkg::CCR_RESET;
      end else if (op_valid_in) begin
         ccr_q <= ccr_d;
      end else if (sw_write) begin
         ccr_q <= avs_writedata_in[7:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         opcount_q <= ccr_flags_pkg::OPCOUNT_RESET;
      end else if (op_valid_in) begin
         opcount_q <= opcount_q + 16'h0001;
      end
   end

   // Every access is answered one cycle after it is presented.
   wire bus_req = avs_read_in | avs_write_in;
   wire [31:0] rd_mux = flags_hit ? {24'h0, ccr_q} :
                        count_hit ? {16'h0, opcount_q} : 32'h0;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ack_q <= bus_req & ~ack_q;
         if (avs_read_in & ~ack_q) begin
            rdata_q <= rd_mux;
         end
      end
   end

   assign avs_waitrequest_out = bus_req & ~ack_q;
   assign avs_readdata_out = rdata_q;
   assign ccr_out = ccr_q;

   wire is_byte = op_in.size == ccr_flags_pkg::size_byte;

   AST_LOAD_COPY: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::control_register_load_op
      && !op_in.to_extended |=> ccr_q == $past(op_in.res[7:0]))
      else $error("flags not loaded from result");
   AST_EXT_KEEPS: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::control_register_load_op
      && op_in.to_extended |=> ccr_q == $past(ccr_q))
      else $error("flags changed on extended register load");
   AST_MOVE_NZ: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::logic_move_op && is_byte
      |=> ccr_q[ZB] == ($past(op_in.res[7:0]) == 8'h00)
      && ccr_q[NB] == $past(op_in.res[7]) && !ccr_q[VB])
      else $error("move flags wrong");
   AST_ADD_V: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::add_op && is_byte
      && op_in.src[7] == op_in.dst[7] && op_in.res[7] != op_in.dst[7]
      |=> ccr_q[VB])
      else $error("add overflow missed");
   AST_ADD_WITH_CARRY_OP_Z: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::add_with_carry_op
      && !ccr_q[ZB] |=> !ccr_q[ZB])
      else $error("chained zero set without prior zero");
   AST_INC_KEEP: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::increment_op
      |=> ccr_q[HB] == $past(ccr_q[HB]) && ccr_q[CB] == $past(ccr_q[CB]))
      else $error("increment touched carry");
   AST_SHL_C: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::shift_left_op && is_byte
      |=> ccr_q[CB] == ($past(op_in.two_bit) ? $past(op_in.dst[6])
                                             : $past(op_in.dst[7])))
      else $error("left shift carry wrong");
   AST_BIT_INVERTED_XOR_OP_C: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::bit_inverted_xor_op
      |=> ccr_q[CB] == ($past(ccr_q[CB]) == $past(op_in.bit_val)))
      else $error("inverted bit xor carry wrong");
   AST_MULU_KEEP: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::unsigned_multiply_op
      |=> $stable(ccr_q))
      else $error("unsigned multiply changed flags");
   AST_TAS_V: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::test_and_set_op
      |=> !ccr_q[VB] && ccr_q[ZB] == ($past(op_in.dst[7:0]) == 8'h00))
      else $error("test-and-set flags wrong");
   AST_ADD_H: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::add_op && is_byte
      |=> ccr_q[HB] == $past(op_in.src[3] & op_in.dst[3]
      | op_in.dst[3] & ~op_in.res[3] | op_in.src[3] & ~op_in.res[3]))
      else $error("add half-carry wrong");
   AST_ADD_C: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::add_op && is_byte
      |=> ccr_q[CB] == $past(op_in.src[7] & op_in.dst[7]
      | op_in.dst[7] & ~op_in.res[7] | op_in.src[7] & ~op_in.res[7]))
      else $error("add carry wrong");
   AST_SUB_H: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::subtract_op && is_byte
      |=> ccr_q[HB] == $past(op_in.src[3] & ~op_in.dst[3]
      | ~op_in.dst[3] & op_in.res[3] | op_in.src[3] & op_in.res[3]))
      else $error("subtract half-carry wrong");
   AST_SUB_C: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::subtract_op && is_byte
      |=> ccr_q[CB] == $past(op_in.src[7] & ~op_in.dst[7]
      | ~op_in.dst[7] & op_in.res[7] | op_in.src[7] & op_in.res[7]))
      else $error("subtract carry wrong");
   AST_INC_V: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::increment_op && is_byte
      |=> ccr_q[VB] == $past(~op_in.dst[7] & op_in.res[7]))
      else $error("increment overflow wrong");
   AST_SHR_C: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::logic_shift_right_op
      && is_byte
      |=> ccr_q[CB] == ($past(op_in.two_bit) ? $past(op_in.dst[1])
                                             : $past(op_in.dst[0])))
      else $error("right shift carry wrong");
   AST_DIV_Z: assert property (@(posedge clk_in)
      disable iff (reset_in)
      op_valid_in && op_in.code == ccr_flags_pkg::signed_divide_op && is_byte
      |=> ccr_q[ZB] == ($past(op_in.src[7:0]) == 8'h00))
      else $error("divide zero flag wrong");
endmodule

/* File: verification/op_source_model.sv */
module op_source_model (
   input wire logic clk_in,
   output logic op_valid_out,
   output ccr_flags_pkg::op_s op_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      op_valid_out = 1'b0;
      op_out = '0;
   end

   // The operand lines are scrambled once valid drops, so nothing can lean
   // on stale values.
   task automatic send(input ccr_flags_pkg::op_s o);
      @(posedge clk_in);
      op_valid_out <= 1'b1;
      op_out <= o;
      @(posedge clk_in);
      op_valid_out <= 1'b0;
      op_out <= ~o;
   endtask
endmodule

/* File: verification/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic op_valid;
   ccr_flags_pkg::op_s op;
   logic [7:0] ccr;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n_ops = 0;
   logic [31:0] rd;
   ccr_flags_pkg::op_s o;

   always #2.5 clk_in = ~clk_in;

   op_source_model dp (
      .clk_in(clk_in),
      .op_valid_out(op_valid),
      .op_out(op)
   );

   condition_code_flag_logic uut (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .op_valid_in(op_valid),
      .op_in(op),
      .ccr_out(ccr),
      .avs_address_in(avs_address),
      .avs_read_in(avs_read),
      .avs_write_in(avs_write),
      .avs_writedata_in(avs_writedata),
      .avs_byteenable_in(avs_byteenable),
      .avs_readdata_out(avs_readdata),
      .avs_waitrequest_out(avs_waitrequest)
   );

   task automatic give_verdict();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge clk_in);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= 4'hF;
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge clk_in); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   function automatic ccr_flags_pkg::op_s mk(
      input ccr_flags_pkg::op_e c, input logic [1:0] s,
      input logic [31:0] sr, ds, rs);
      mk = '0;
      mk.code = c;
      mk.size = ccr_flags_pkg::size_e'(s);
      mk.src = sr;
      mk.dst = ds;
      mk.res = rs;
   endfunction

   task automatic run(input ccr_flags_pkg::op_s x, input logic [7:0] e);
      dp.send(x);
      n_ops++;
      @(negedge clk_in);
      chk("ccr_out", {24'h0, e}, {24'h0, ccr});
   endtask

   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         give_verdict();
      end
   end

   initial begin
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      @(negedge clk_in);
      chk("ccr_out", 32'h0, {24'h0, ccr});
      bus(1'b0, ccr_flags_pkg::FLAGS_ADDR, 32'h0);
      chk("flags", 32'h0, rd);
      bus(1'b0, ccr_flags_pkg::OPCOUNT_ADDR, 32'h0);
      chk("opcount", 32'h0, rd);
      bus(1'b1, ccr_flags_pkg::FLAGS_ADDR, 32'hFF);
      bus(1'b0, ccr_flags_pkg::FLAGS_ADDR, 32'h0);
      chk("flags", 32'hFF, rd);
      run(mk(ccr_flags_pkg::logic_move_op, 2'h0, 0, 0, 0), 8'hF5);
      o = mk(ccr_flags_pkg::control_register_load_op, 2'h0, 0, 0, 0);
      o.to_extended = 1'b1;
      run(o, 8'hF5);
      o.to_extended = 1'b0;
      o.res = 32'h2B;
      run(o, 8'h2B);
      o = mk(ccr_flags_pkg::add_op, 2'h0, 32'h0F, 32'h01, 32'h10);
      run(o, 8'h20);
      o = mk(ccr_flags_pkg::add_op, 2'h1, 32'h8000, 32'h8000, 32'h0);
      run(o, 8'h07);
      o = mk(ccr_flags_pkg::add_with_carry_op, 2'h0, 0, 0, 0);
      run(o, 8'h04);
      o.dst = 32'h1;
      o.res = 32'h1;
      run(o, 8'h00);
      o = mk(ccr_flags_pkg::add_with_carry_op, 2'h0, 0, 0, 0);
      run(o, 8'h00);
      o = mk(ccr_flags_pkg::subtract_op, 2'h2, 32'h1, 0, 32'hFFFFFFFF);
      run(o, 8'h29);
      bus(1'b1, ccr_flags_pkg::FLAGS_ADDR, 32'h21);
      o = mk(ccr_flags_pkg::increment_op, 2'h0, 0, 32'h7F, 32'h80);
      run(o, 8'h2B);
      o = mk(ccr_flags_pkg::decrement_op, 2'h1, 0, 32'h8000, 32'h7FFF);
      run(o, 8'h23);
      o = mk(ccr_flags_pkg::decimal_adjust_add_op, 2'h0, 0, 0, 0);
      o.dec_carry = 1'b1;
      run(o, 8'h27);
      o = mk(ccr_flags_pkg::decimal_adjust_sub_op, 2'h0, 0, 0, 32'h80);
      run(o, 8'h2A);
      o = mk(ccr_flags_pkg::signed_divide_op, 2'h0, 32'h80, 32'h8000, 0);
      run(o, 8'h22);
      o = mk(ccr_flags_pkg::signed_divide_op, 2'h0, 0, 0, 0);
      run(o, 8'h26);
      o = mk(ccr_flags_pkg::unsigned_divide_op, 2'h1, 32'h8000, 0, 0);
      run(o, 8'h2A);
      o = mk(ccr_flags_pkg::signed_multiply_op, 2'h0, 0, 0, 0);
      run(o, 8'h26);
      o.res = 32'h0100;
      run(o, 8'h22);
      o = mk(ccr_flags_pkg::unsigned_multiply_op, 2'h0, 0, 0, 0);
      run(o, 8'h22);
      o = mk(ccr_flags_pkg::shift_left_op, 2'h0, 0, 32'h80, 0);
      run(o, 8'h25);
      o.two_bit = 1'b1;
      run(o, 8'h24);
      o = mk(ccr_flags_pkg::shift_right_op, 2'h1, 0, 32'h1, 0);
      run(o, 8'h25);
      o.two_bit = 1'b1;
      run(o, 8'h24);
      o = mk(ccr_flags_pkg::test_and_set_op, 2'h0, 0, 0, 32'h80);
      run(o, 8'h24);
      o = mk(ccr_flags_pkg::bit_inverted_xor_op, 2'h0, 0, 0, 0);
      run(o, 8'h25);
      o = mk(ccr_flags_pkg::bit_xor_op, 2'h0, 0, 0, 0);
      o.bit_val = 1'b1;
      run(o, 8'h24);
      o = mk(ccr_flags_pkg::add_op, 2'h0, 32'h7F, 32'h01, 32'h80);
      run(o, 8'h2A);
      o = mk(ccr_flags_pkg::arith_shift_left_op, 2'h0, 0, 32'h40, 32'h80);
      run(o, 8'h2A);
      o = mk(ccr_flags_pkg::logic_shift_right_op, 2'h0, 0, 32'h03, 32'h81);
      run(o, 8'h21);
      o = mk(ccr_flags_pkg::subtract_op, 2'h0, 32'h01, 32'h00, 32'hFF);
      run(o, 8'h29);
      bus(1'b1, ccr_flags_pkg::OPCOUNT_ADDR, 32'h1234);
      bus(1'b0, ccr_flags_pkg::OPCOUNT_ADDR, 32'h0);
      chk("opcount", n_ops, rd);
      bus(1'b0, 4'hC, 32'h0);
      chk("unmapped", 32'h0, rd);
      give_verdict();
   end
endmodule
